//--- core/mtp_core.sv
/*
  Receive filter, checksum check, packet buffers, time-stamp timer, gap stretch and APB registers.
  Assumes the MAC delivers bytes with per-frame status on the last byte and a synchronous APB host.
*/
`timescale 1ns/100ps

// ***************************************************
// Small synchronous FIFO
// ***************************************************
module mtp_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_r, rd_r;
  logic push, pop;

  // Full and empty come straight from the pointer distance
  assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign out_data = mem[rd_r[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end
endmodule

// ***************************************************
// Top level
// ***************************************************
module mtp_core #(
  parameter int RX_DEPTH = 256,
  parameter int TX_DEPTH = 256,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mtp_pkg::mtp_rx_byte_s rx_in,
  input wire mtp_pkg::mtp_rx_stat_s rx_stat,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic wol_event,
  output mtp_pkg::mtp_byte_s sys_wr,
  output logic sys_wr_valid,
  input wire logic sys_wr_ready,
  input wire mtp_pkg::mtp_byte_s tx_in,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  output mtp_pkg::mtp_byte_s tx_out,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  input wire logic tx_col
);
  import mtp_pkg::*;

  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);

  logic [7:0] ncfg_r;
  logic [31:0] tpsf_r, rpsf_r, mfr_r;
  logic [15:0] ipgs_r;
  logic [23:0] tinc_r;
  logic [47:0] sec_r;
  logic [45:0] lo_r;
  logic wr_en, rd_setup, psf_tx, psf_rx;

  // ***************************************************
  // APB slave: zero wait state, data latched in setup
  // ***************************************************
  assign rd_setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;
  assign psf_tx = tpsf_r[PSF_ENABLE] & ncfg_r[NCFG_FULL_DUPLEX]; // R14
  assign psf_rx = rpsf_r[PSF_ENABLE] & ncfg_r[NCFG_FULL_DUPLEX]; // R14

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_setup;
      pslverr <= 1'b0;
      if (rd_setup) begin
        unique case (paddr)
          ADDR_NCFG: prdata <= {24'h00_0000, ncfg_r};
          ADDR_CTRL: prdata <= 32'h0000_0000;
          ADDR_TPSF: prdata <= tpsf_r;
          ADDR_RPSF: prdata <= rpsf_r;
          ADDR_IPGS: prdata <= {16'h0000, ipgs_r};
          ADDR_MFR: prdata <= mfr_r;
          ADDR_TSH: prdata <= {16'h0000, sec_r[47:32]};
          ADDR_TSL: prdata <= sec_r[31:0];
          ADDR_TN: prdata <= {2'b00, lo_r[45:16]}; // R5 R6
          ADDR_TINC: prdata <= {8'h00, tinc_r};
          ADDR_TADJ: prdata <= 32'h0000_0000;
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Software-writable configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ncfg_r <= NCFG_RST;
      tpsf_r <= PSF_RST;
      rpsf_r <= PSF_RST;
      ipgs_r <= IPGS_RST;
      tinc_r <= TINC_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_NCFG) ncfg_r <= pwdata[7:0];
      if (paddr == ADDR_TPSF) tpsf_r <= pwdata;
      if (paddr == ADDR_RPSF) rpsf_r <= pwdata;
      if (paddr == ADDR_IPGS) ipgs_r <= pwdata[15:0];
      if (paddr == ADDR_TINC) tinc_r <= pwdata[23:0];
    end
  end

  // ***************************************************
  // Time stamp timer: seconds, nanoseconds, fraction
  // ***************************************************
  logic adj_wr;
  logic [47:0] lo_sum, adj_term, lo_calc;
  assign adj_wr = wr_en && (paddr == ADDR_TADJ);
  assign lo_sum = {2'b00, lo_r} + {24'h00_0000, tinc_r}; // R8
  assign adj_term = {2'b00, pwdata[29:0], 16'h0000}; // R9
  // Step and increment are merged so neither is lost in a write cycle
  assign lo_calc = !adj_wr ? lo_sum : pwdata[ADJ_SUBTRACT] ? lo_sum - adj_term : lo_sum + adj_term; // R19

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lo_r <= 46'h0;
      sec_r <= 48'h0;
    end else begin
      if (lo_calc[47]) begin
        lo_r <= 46'(lo_calc + {2'b00, ONE_SEC_SUB}); // R7
        sec_r <= sec_r - 48'h1;
      end else if (lo_calc >= {2'b00, ONE_SEC_SUB}) begin
        lo_r <= 46'(lo_calc - {2'b00, ONE_SEC_SUB}); // R7
        sec_r <= sec_r + 48'h1; // R4
      end else begin
        lo_r <= lo_calc[45:0];
      end
      // A seconds write overrides the carry in the same cycle only in the word (TSH or TSL) that it writes
      if (wr_en && paddr == ADDR_TSH) sec_r[47:32] <= pwdata[15:0];
      if (wr_en && paddr == ADDR_TSL) sec_r[31:0] <= pwdata;
    end
  end

  // ***************************************************
  // Receive filter and checksum
  // ***************************************************
  logic [15:0] cks_acc_r, cks_word, cks_fin;
  logic [16:0] cks_sum;
  logic [7:0] cks_hi_r;
  logic cks_odd_r, cks_ok, filt_ok, frame_bad, keep, mc_ok;

  always_comb begin
    cks_word = cks_odd_r ? {cks_hi_r, rx_in.data} : {rx_in.data, 8'h00};
    cks_sum = {1'b0, cks_acc_r} + {1'b0, cks_word};
    cks_fin = cks_sum[15:0] + 16'(cks_sum[16]); // R3
    if (!rx_in.cks) begin
      cks_fin = cks_acc_r;
    end
  end

  // An odd trailing byte pairs with a zero low byte
  always_ff @(posedge clk_sys) begin
    if (rst || (rx_valid && rx_in.last)) begin
      cks_acc_r <= 16'h0000;
      cks_odd_r <= 1'b0;
      cks_hi_r <= 8'h00;
    end else if (rx_valid && rx_in.cks) begin
      cks_odd_r <= ~cks_odd_r;
      cks_hi_r <= rx_in.data;
      if (cks_odd_r) cks_acc_r <= cks_fin;
    end
  end

  assign cks_ok = (cks_fin == CKS_GOOD) || (cks_fin == 16'h0000); // R3
  assign filt_ok = (ncfg_r[NCFG_COPY_ALL] | rx_stat.addr_match |
                    ((rx_stat.dest == BCAST_ADDR) & ~ncfg_r[NCFG_NO_BCAST])) // R1
                   & ~(ncfg_r[NCFG_VLAN_ONLY] & ~rx_stat.vlan); // R2
  assign frame_bad = rx_stat.crc_err | (ncfg_r[NCFG_CKS_DISCARD] & ~cks_ok); // R3
  assign mc_ok = rx_stat.mcast & ~rx_stat.pause & ~rx_stat.crc_err & cks_ok; // R18

  // ***************************************************
  // Receive packet buffer
  // ***************************************************
  logic [9:0] rx_mem [RX_DEPTH];
  logic [RAW:0] rx_wr_r, rx_fs_r, rx_cm_r, rx_rd_r, rx_used, rx_fill;
  logic rx_drop_r, rx_inframe_r, rx_space, rx_wen, flush_wr;
  logic [9:0] fifo_out;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;

  assign flush_wr = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_RX_FLUSH];
  assign rx_used = rx_wr_r - rx_rd_r;
  assign rx_space = rx_used != (RAW+1)'(RX_DEPTH);
  assign rx_wen = rx_valid & ~rx_drop_r & rx_space & ~flush_wr;
  assign rx_fill = rx_wr_r + (RAW+1)'(1) - rx_fs_r;
  // Partially committed frames cannot be withdrawn any more
  assign keep = filt_ok & (~frame_bad | psf_rx | (rx_cm_r != rx_fs_r)); // R12

  always_ff @(posedge clk_sys) begin
    if (rx_wen) begin
      rx_mem[rx_wr_r[RAW-1:0]] <= {rx_in.last & keep & mc_ok, rx_in.last, rx_in.data}; // R10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_wr_r <= '0;
      rx_fs_r <= '0;
      rx_cm_r <= '0;
      rx_drop_r <= 1'b0;
      rx_inframe_r <= 1'b0;
      wol_event <= 1'b0;
    end else begin
      wol_event <= rx_wen & rx_in.last & rx_stat.wol & ncfg_r[NCFG_WOL_EN]; // R2
      if (flush_wr) begin
        rx_wr_r <= rx_cm_r; // R13
        rx_drop_r <= rx_inframe_r | (rx_valid & ~rx_in.last);
        rx_inframe_r <= rx_valid ? ~rx_in.last : rx_inframe_r;
      end else if (rx_valid && rx_drop_r) begin
        rx_drop_r <= ~rx_in.last;
        rx_inframe_r <= ~rx_in.last;
      end else if (rx_valid && !rx_space) begin
        rx_wr_r <= rx_cm_r; // R13
        rx_drop_r <= ~rx_in.last;
        rx_inframe_r <= ~rx_in.last;
      end else if (rx_wen && rx_in.last) begin
        rx_inframe_r <= 1'b0;
        if (keep) begin
          rx_wr_r <= rx_wr_r + (RAW+1)'(1);
          rx_cm_r <= rx_wr_r + (RAW+1)'(1);
          rx_fs_r <= rx_wr_r + (RAW+1)'(1);
        end else begin
          rx_wr_r <= rx_cm_r; // R12
          rx_fs_r <= rx_cm_r;
        end
      end else if (rx_wen) begin
        rx_inframe_r <= 1'b1;
        rx_wr_r <= rx_wr_r + (RAW+1)'(1);
        if (psf_rx && 16'(rx_fill) >= rpsf_r[15:0]) rx_cm_r <= rx_wr_r + (RAW+1)'(1); // R14
      end
    end
  end

  // Without auto flush the MAC is held off; with it, a full buffer drops the frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_ready <= 1'b0;
      rx_rd_r <= '0;
    end else begin
      rx_ready <= ncfg_r[NCFG_AUTO_FLUSH] | (rx_used < (RAW+1)'(RX_DEPTH - 2)); // R13
      if (rx_rd_r != rx_cm_r && fifo_in_ready) rx_rd_r <= rx_rd_r + (RAW+1)'(1);
    end
  end

  mtp_fifo #(.W(10), .DEPTH(FIFO_DEPTH)) mtp_fifo_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_data(rx_mem[rx_rd_r[RAW-1:0]]),
    .in_valid(rx_rd_r != rx_cm_r),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // System-side output register and multicast counter
  logic sys_mc_r;
  assign fifo_out_ready = ~sys_wr_valid | sys_wr_ready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_wr_valid <= 1'b0;
      sys_wr <= '0;
      sys_mc_r <= 1'b0;
      mfr_r <= MFR_RST;
    end else begin
      if (sys_wr_valid && sys_wr_ready && sys_mc_r) mfr_r <= mfr_r + 32'h1; // R18
      if (fifo_out_ready) begin
        sys_wr_valid <= fifo_out_valid;
        sys_wr <= '{data: fifo_out[7:0], last: fifo_out[8]};
        sys_mc_r <= fifo_out[9];
      end
    end
  end

  // ***************************************************
  // Transmit packet buffer and gap control
  // ***************************************************
  mtp_byte_s tx_mem [TX_DEPTH];
  mtp_tx_state_e tx_st_r;
  logic [TAW:0] tx_wr_r, tx_rd_r, tx_fs_r, tx_held;
  logic [15:0] tx_frames_r, tx_len_r, fr_len;
  logic [23:0] gap_r, prod, stretch, gap_val;
  logic tx_wen, tx_hs, tx_hs_last, tx_load, tx_replay;

  assign tx_held = tx_wr_r - tx_fs_r;
  assign tx_wen = tx_in_valid & tx_in_ready;
  assign tx_hs = tx_out_valid & tx_out_ready;
  assign tx_hs_last = tx_hs & tx_out.last;
  assign tx_replay = (tx_st_r == TX_SEND) & tx_col & ~psf_tx; // R11
  assign tx_load = (tx_st_r == TX_SEND) & ~tx_replay & (~tx_out_valid | tx_out_ready) & ~tx_hs_last &
                   (tx_rd_r != tx_wr_r);
  assign fr_len = tx_len_r + 16'h1 + PREAMBLE_LEN;
  assign prod = 24'(fr_len) * 24'(ipgs_r[7:0]);
  assign stretch = prod / (24'(ipgs_r[15:8]) + 24'h1); // R16
  assign gap_val = (ncfg_r[NCFG_GAP_STRETCH] && stretch > GAP_MIN) ? stretch : GAP_MIN; // R17

  always_ff @(posedge clk_sys) begin
    if (tx_wen) begin
      tx_mem[tx_wr_r[TAW-1:0]] <= tx_in;
    end
  end

  // Space counts from the frame start so a collided frame is still held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_wr_r <= '0;
      tx_frames_r <= 16'h0000;
      tx_in_ready <= 1'b0;
    end else begin
      tx_in_ready <= tx_held < (TAW+1)'(TX_DEPTH - 2); // R10
      if (tx_wen) tx_wr_r <= tx_wr_r + (TAW+1)'(1);
      tx_frames_r <= tx_frames_r + 16'(tx_wen & tx_in.last) - 16'(tx_hs_last);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_r <= TX_IDLE;
      tx_rd_r <= '0;
      tx_fs_r <= '0;
      tx_len_r <= 16'h0000;
      gap_r <= 24'h00_0000;
      tx_out_valid <= 1'b0;
      tx_out <= '0;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          // Full mode waits for a whole frame
          if (tx_frames_r != 16'h0000 || (psf_tx && 16'(tx_wr_r - tx_rd_r) >= tpsf_r[15:0])) begin // R15
            tx_st_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_replay) begin
            tx_rd_r <= tx_fs_r; // R11
            tx_out_valid <= 1'b0;
            tx_len_r <= 16'h0000;
          end else begin
            if (tx_hs) tx_len_r <= tx_len_r + 16'h1;
            if (tx_hs_last) begin
              tx_st_r <= TX_GAP;
              tx_fs_r <= tx_rd_r;
              gap_r <= gap_val; // R17
              tx_len_r <= 16'h0000;
            end
            if (tx_load) begin
              tx_out <= tx_mem[tx_rd_r[TAW-1:0]];
              tx_out_valid <= 1'b1;
              tx_rd_r <= tx_rd_r + (TAW+1)'(1);
            end else if (tx_hs) begin
              tx_out_valid <= 1'b0;
            end
          end
        end
        TX_GAP: begin
          gap_r <= gap_r - 24'h1;
          if (gap_r == 24'h1) tx_st_r <= TX_IDLE;
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_last_out;
    tx_hs_last ##1 (tx_st_r == TX_GAP);
  endsequence

  AST_LO_BELOW_SEC: assert property (lo_r < ONE_SEC_SUB) else $error("fraction not below one second"); // R7
  AST_TS_ADVANCE: assert property (!adj_wr && !(wr_en && paddr[8:4] == 5'h1D) |=>
    (lo_r == 46'($past(lo_sum))) || (sec_r == $past(sec_r) + 48'h1)) else $error("timer increment lost"); // R8
  AST_TS_STEP: assert property (adj_wr && !pwdata[ADJ_SUBTRACT] && !$past(rst) |=>
    (lo_r == 46'($past(lo_sum) + $past(adj_term))) || (sec_r != $past(sec_r))) else $error("step lost"); // R19
  AST_MC_COUNT: assert property (!(sys_wr_valid && sys_wr_ready && sys_mc_r) |=> $stable(mfr_r))
    else $error("multicast count moved"); // R18
  AST_BAD_DROP: assert property (rx_wen && rx_in.last && rx_stat.crc_err && !psf_rx |=> rx_wr_r == rx_cm_r)
    else $error("bad frame kept"); // R12
  AST_BCAST: assert property (rx_wen && rx_in.last && rx_stat.dest == BCAST_ADDR && !ncfg_r[NCFG_NO_BCAST] &&
    !ncfg_r[NCFG_VLAN_ONLY] && !frame_bad |=> rx_cm_r == $past(rx_wr_r) + (RAW+1)'(1)) else $error("bcast lost"); // R1
  AST_GAP_HOLD: assert property (s_last_out |-> !tx_out_valid [*8]) else $error("gap too short"); // R17
  AST_FULL_START: assert property ((tx_st_r == TX_IDLE) && tx_frames_r == 16'h0000 && !psf_tx |=>
    tx_st_r == TX_IDLE) else $error("started before frame complete"); // R15
  AST_PSF_DUPLEX: assert property (!ncfg_r[NCFG_FULL_DUPLEX] && tx_st_r == TX_IDLE && tx_frames_r == 16'h0000 |=>
    tx_st_r == TX_IDLE) else $error("partial mode in half duplex"); // R14
endmodule

//--- core/mtp_pkg.sv
/*
  Shared constants, register map and carrier types of the MAC time-stamp and packet-buffer block.
  Assumes a single 20 MHz system clock and a synchronous active-high reset in every user.
*/
// Overview of operation
// [R1] Receive filter accepts all-ones broadcast destination; a copy-all mode accepts every frame; here VLAN-only still rejects untagged ones.
// [R2] Optional rejection of untagged frames; wake-on-LAN frames raise an event.
// [R3] Ones-complement checksum over marked bytes; bad checksum frames optionally discarded.
// [R4] Timer is 94 bits; top 48 bits count whole seconds.
// [R5] Timer bits 45..16 hold a 30-bit nanoseconds count readable by software.
// [R6] Lowest 16 timer bits count sub-nanoseconds, hidden from the nanoseconds field.
// [R7] Lower 46 bits wrap at one second and carry into seconds.
// [R8] Timer adds a programmable sub-nanosecond resolution increment every clock.
// [R9] Software can step the timer up or down in whole nanoseconds.
// [R10] Packet memories buffer several whole frames between MAC and system side.
// [R11] Full store-and-forward replays a collided frame from the packet buffer.
// [R12] Full store-and-forward drops erroneous received frames before system memory sees them.
// [R13] Software receive flush, plus optional automatic flush when system side stalls.
// [R14] Partial store-and-forward works only while full duplex is configured.
// [R15] Partial transmit starts only once enough packet bytes are buffered.
// [R16] Stretch result is frame length with preamble times low byte over high byte plus one.
// [R17] Stretch result is the gap only if above 96 and stretch is enabled.
// [R18] 32-bit counter of good non-pause multicast frames copied to memory.
// [R19] Nanosecond correction and the regular increment both apply in the same cycle.
package mtp_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [8:0] ADDR_NCFG = 9'h000;
  localparam logic [8:0] ADDR_CTRL = 9'h004;
  localparam logic [8:0] ADDR_TPSF = 9'h040;
  localparam logic [8:0] ADDR_RPSF = 9'h044;
  localparam logic [8:0] ADDR_IPGS = 9'h0BC;
  localparam logic [8:0] ADDR_MFR = 9'h160;
  localparam logic [8:0] ADDR_TSH = 9'h1D0;
  localparam logic [8:0] ADDR_TSL = 9'h1D4;
  localparam logic [8:0] ADDR_TN = 9'h1D8;
  localparam logic [8:0] ADDR_TINC = 9'h1DC;
  localparam logic [8:0] ADDR_TADJ = 9'h1E0;

  // network_config_reg bit positions, then control, PSF enable and adjust subtract bits
  localparam int NCFG_COPY_ALL = 0;
  localparam int NCFG_NO_BCAST = 1;
  localparam int NCFG_VLAN_ONLY = 2;
  localparam int NCFG_CKS_DISCARD = 3;
  localparam int NCFG_FULL_DUPLEX = 4;
  localparam int NCFG_GAP_STRETCH = 5;
  localparam int NCFG_WOL_EN = 6;
  localparam int NCFG_AUTO_FLUSH = 7;
  localparam int CTRL_RX_FLUSH = 0;
  localparam int PSF_ENABLE = 31;
  localparam int ADJ_SUBTRACT = 31;

  // Reset values
  localparam logic [7:0] NCFG_RST = 8'h00;
  localparam logic [31:0] PSF_RST = 32'h0000_0000;
  localparam logic [15:0] IPGS_RST = 16'h0000;
  localparam logic [31:0] MFR_RST = 32'h0000_0000;
  localparam logic [23:0] TINC_RST = 24'h00_0000;

  // ***************************************************
  // Time stamp and frame constants
  // ***************************************************
  localparam logic [45:0] ONE_SEC_SUB = 46'h3B9A_CA00_0000;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
  localparam logic [23:0] GAP_MIN = 24'h00_0060;
  localparam logic [15:0] PREAMBLE_LEN = 16'h0008;
  localparam logic [15:0] CKS_GOOD = 16'hFFFF;

  // ***************************************************
  // Carrier types
  // ***************************************************
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mtp_byte_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic cks;
  } mtp_rx_byte_s;

  typedef struct packed {
    logic [47:0] dest;
    logic addr_match;
    logic vlan;
    logic wol;
    logic mcast;
    logic pause;
    logic crc_err;
  } mtp_rx_stat_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_GAP = 3'b100
  } mtp_tx_state_e;

endpackage

//--- testbench/mtp_mac_model.sv
/*
  MAC-side partner: sends receive frames, takes transmit bytes and times the gap between frames.
  Assumes the 20 MHz system clock of the core.
*/
`timescale 1ns/100ps
module mtp_mac_model (
  input wire logic clk_sys,
  output mtp_pkg::mtp_rx_byte_s rx_in,
  output mtp_pkg::mtp_rx_stat_s rx_stat,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire mtp_pkg::mtp_byte_s tx_out,
  input wire logic tx_out_valid,
  output logic tx_out_ready,
  output logic tx_col
);
  import mtp_pkg::*;
  logic [7:0] tx_q[$];
  int gap_cnt = 0;
  int gap_seen = 0;
  logic gap_on = 1'b0;
  // ****
  // Line idle state
  // ****
  initial begin
    tx_col = 1'b0;
    rx_in = '0;
    rx_stat = '0;
    rx_valid = 1'b0;
    tx_out_ready = 1'b0;
  end
  // Sends n counting bytes; idle data is inverted so a stale byte never looks valid
  task automatic send(input mtp_rx_stat_s st, input int n, input logic ck = 1'b0);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      while (rx_ready !== 1'b1) begin
        rx_valid <= 1'b0;
        @(posedge clk_sys);
      end
      rx_in <= '{data: 8'(i + 16), last: (i == n - 1), cks: ck};
      rx_stat <= st;
      rx_valid <= 1'b1;
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_in.data <= ~rx_in.data;
  endtask
  // Collision pulse; the cut frame's bytes are forgotten once the core has dropped its output
  task automatic collide();
    tx_col <= 1'b1;
    @(posedge clk_sys);
    tx_col <= 1'b0;
    @(posedge clk_sys);
    tx_q.delete();
  endtask
  // Slow taker: ready every other cycle, so the core must hold each byte
  always @(posedge clk_sys) begin
    tx_out_ready <= ~tx_out_ready;
    if (tx_out_valid && tx_out_ready) begin
      tx_q.push_back(tx_out.data);
    end
    if (tx_out_valid && tx_out_ready && tx_out.last) begin
      gap_on <= 1'b1;
      gap_cnt <= 0;
    end else if (gap_on && tx_out_valid) begin
      gap_seen <= gap_cnt;
      gap_on <= 1'b0;
    end else begin
      gap_cnt <= gap_cnt + 1;
    end
  end
endmodule

//--- testbench/tb_mtp_core.sv
/*
  Self-checking bench of the core: registers, timer, receive filter and transmit gap.
  Assumes the MAC partner model and a system side that is always ready.
*/
`timescale 1ns/100ps
module tb_mtp_core;
  import mtp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [8:0] paddr;
  logic [31:0] pwdata, prdata, rd, t;
  mtp_rx_byte_s rx_in;
  mtp_rx_stat_s rx_stat;
  mtp_byte_s sys_wr, tx_in, tx_out;
  logic rx_valid, rx_ready, wol_event, sys_wr_valid, tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready, tx_col;
  logic sys_wr_ready = 1'b1;
  logic [7:0] sys_q[$];
  int errors = 0;
  int samples_checked = 0;
  int wol_cnt = 0;
  mtp_core mtp_core_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .rx_stat(rx_stat), .rx_valid(rx_valid), .rx_ready(rx_ready), .wol_event(wol_event), .sys_wr(sys_wr),
    .sys_wr_valid(sys_wr_valid), .sys_wr_ready(sys_wr_ready), .tx_in(tx_in), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_out(tx_out), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_col(tx_col));
  mtp_mac_model mtp_mac_model_inst (.clk_sys(clk_sys), .rx_in(rx_in), .rx_stat(rx_stat), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_out(tx_out), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_col(tx_col));
  // ****
  // Common tasks
  // ****
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (sys_wr_valid && sys_wr_ready) sys_q.push_back(sys_wr.data);
  always @(posedge clk_sys) if (wol_event === 1'b1) wol_cnt++;
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // One zero-wait APB access; read data and error land in rd and er
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    chk("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_done();
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    apb(0, ADDR_IPGS, 0);
    chk("ipgs", rd, 32'h0);
    apb(1, ADDR_MFR, 32'h5);
    apb(0, ADDR_MFR, 0);
    chk("mfr", rd, 32'h0);
    apb(0, 9'h0F0, 0);
    chk("slverr", {31'h0, er}, 32'h1);
  endtask
  // Timer frozen with zero increment, then each access spans three cycles
  task automatic t_timer();
    apb(0, ADDR_TN, 0);
    chk("ns", rd, 32'h0);
    apb(1, ADDR_TADJ, 32'h5);
    apb(1, ADDR_TADJ, 32'h8000_0002);
    apb(0, ADDR_TN, 0);
    chk("ns", rd, 32'h3);
    apb(1, ADDR_TADJ, 32'd999999996);
    apb(0, ADDR_TN, 0);
    chk("ns", rd, 32'd999999999);
    apb(1, ADDR_TADJ, 32'h1);
    apb(0, ADDR_TN, 0);
    chk("ns", rd, 32'h0);
    apb(0, ADDR_TSL, 0);
    chk("sec", rd, 32'h1);
    apb(1, ADDR_TINC, 32'h0001_0000);
    apb(0, ADDR_TN, 0);
    t = rd;
    apb(0, ADDR_TN, 0);
    chk("ns", rd, t + 32'd3);
    apb(1, ADDR_TADJ, 32'd100);
    apb(0, ADDR_TN, 0);
    chk("ns", rd, t + 32'd109);
    apb(1, ADDR_TINC, 0);
  endtask
  task automatic t_rx();
    mtp_mac_model_inst.send({BCAST_ADDR, 6'h04}, 4);
    mtp_mac_model_inst.send({BCAST_ADDR, 6'h05}, 4);
    mtp_mac_model_inst.send({48'h0000_1111_2222, 6'h04}, 4);
    apb(1, ADDR_NCFG, 32'h1);
    mtp_mac_model_inst.send({48'h0000_1111_2222, 6'h04}, 4);
    apb(1, ADDR_NCFG, 32'h5);
    mtp_mac_model_inst.send({48'h0000_1111_2222, 6'h04}, 4);
    apb(1, ADDR_NCFG, 32'h49);
    mtp_mac_model_inst.send({48'h0000_1111_2222, 6'h08}, 4, 1'b1);
    apb(1, ADDR_NCFG, 32'h0);
    repeat (40) @(posedge clk_sys);
    chk("rx count", sys_q.size(), 32'd8);
    chk("wol", wol_cnt, 32'd1);
    for (int i = 0; i < sys_q.size(); i++) chk("rx byte", sys_q[i], (i % 4) + 16);
    apb(0, ADDR_MFR, 0);
    chk("mfr", rd, 32'h2);
  endtask
  // Two frames back to back, first cut once; second waits the stretched gap (4+8)*100/1
  task automatic t_tx();
    apb(1, ADDR_IPGS, 32'h64);
    apb(0, ADDR_IPGS, 0);
    chk("ipgs", rd, 32'h64);
    apb(1, ADDR_NCFG, 32'h20);
    for (int i = 0; i < 8; i++) begin
      tx_in <= '{data: 8'(i + 32), last: (i % 4 == 3)};
      tx_in_valid <= 1'b1;
      do @(posedge clk_sys); while (tx_in_ready !== 1'b1);
    end
    tx_in_valid <= 1'b0;
    while (mtp_mac_model_inst.tx_q.size() < 2) @(posedge clk_sys);
    mtp_mac_model_inst.collide();
    for (int i = 0; i < 4000 && mtp_mac_model_inst.tx_q.size() < 8; i++) @(posedge clk_sys);
    chk("tx count", mtp_mac_model_inst.tx_q.size(), 32'd8);
    for (int i = 0; i < 8; i++) chk("tx byte", mtp_mac_model_inst.tx_q[i], i + 32);
    t = mtp_mac_model_inst.gap_seen;
    chk("gap", {31'h0, t >= 1200 && t <= 1205}, 32'h1);
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    tx_in = '0;
    tx_in_valid = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_timer();
    t_rx();
    t_tx();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    test_done();
  end
endmodule
